// >>> verilog/beal_pkg.sv
// beal_pkg: offsets, field positions, flag positions and reset values of the
// bus error address logger.
// assumes the including modules import the whole package.
package beal_pkg;

  // register offsets within the adapter's node space
  localparam logic [7:0] BEAL_OFF_CMDR_FAIL_ADDR = 8'h08;
  localparam logic [7:0] BEAL_OFF_RSP_ERR_ADDR = 8'h0C;

  // field positions, shared by both capture registers
  localparam int BEAL_LEN_MSB = 31;
  localparam int BEAL_LEN_LSB = 30;
  localparam int BEAL_ADDR_MSB = 29;
  localparam int BEAL_ADDR_LSB = 0;
  localparam int BEAL_CAP_W = 32;

  // error summary fields
  localparam int BEAL_SUM_NODE_MSB = 25;
  localparam int BEAL_SUM_NODE_LSB = 20;
  localparam int BEAL_SUM_CMD_MSB = 19;
  localparam int BEAL_SUM_CMD_LSB = 16;
  localparam int BEAL_SUM_ME_BIT = 14;
  localparam int BEAL_NODE_W = 6;
  localparam int BEAL_CMD_W = 4;
  localparam int BEAL_SUM_FLAG_W = 14;

  // bus error flag positions
  localparam int BEAL_BE_WSEQ = 22;
  localparam int BEAL_BE_RDNOACK = 21;
  localparam int BEAL_BE_WDNOACK = 20;
  localparam int BEAL_BE_NORESP = 18;
  localparam int BEAL_BE_RSEQ = 17;
  localparam int BEAL_BE_RERR = 16;
  localparam int BEAL_BE_CMDNOACK = 15;
  localparam int BEAL_BE_TMO = 13;
  localparam int BEAL_BE_STF = 10;

  // error summary flag positions
  localparam int BEAL_ES_UNCORR = 13;
  localparam int BEAL_ES_CORR = 12;
  localparam int BEAL_ES_INTERR = 7;
  localparam int BEAL_ES_IOWFAIL = 6;
  localparam int BEAL_ES_ACLO = 5;
  localparam int BEAL_ES_RDPAR = 0;

  // lock masks
  localparam logic [31:0] BEAL_CMDR_BE_MASK = (32'h1 << BEAL_BE_WDNOACK)
    | (32'h1 << BEAL_BE_NORESP) | (32'h1 << BEAL_BE_RSEQ) | (32'h1 << BEAL_BE_RERR)
    | (32'h1 << BEAL_BE_CMDNOACK) | (32'h1 << BEAL_BE_TMO);
  localparam logic [13:0] BEAL_CMDR_ES_MASK = 14'h1 << BEAL_ES_INTERR;
  localparam logic [31:0] BEAL_RSP_BE_MASK = (32'h1 << BEAL_BE_WSEQ)
    | (32'h1 << BEAL_BE_RDNOACK);
  localparam logic [13:0] BEAL_RSP_ES_MASK = (14'h1 << BEAL_ES_UNCORR)
    | (14'h1 << BEAL_ES_CORR) | (14'h1 << BEAL_ES_INTERR)
    | (14'h1 << BEAL_ES_IOWFAIL) | (14'h1 << BEAL_ES_RDPAR);

  // flags that never count towards the multiple-error flag
  localparam logic [31:0] BEAL_ME_BE_MASK = ~(32'h1 << BEAL_BE_STF);
  localparam logic [13:0] BEAL_ME_ES_MASK = ~(14'h1 << BEAL_ES_ACLO);

  localparam logic [31:0] BEAL_CAP_RESET = 32'h0000_0000;

endpackage : beal_pkg

// >>> verilog/beal_capture.sv
// beal_capture: one lockable capture register.
// assumes load and lock come from logic on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module beal_capture
  import beal_pkg::*;
#(
  parameter int WIDTH = BEAL_CAP_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic loadEn,
  input wire logic lockHold,
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataQ
);

  logic [WIDTH-1:0] data_d;

  // a locked register keeps the first failing transaction
  assign data_d = (loadEn && !lockHold) ? dataIn : dataQ; // (R15)

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dataQ <= WIDTH'(BEAL_CAP_RESET);
    end else begin
      dataQ <= data_d;
    end
  end

endmodule : beal_capture

`default_nettype wire

// >>> verilog/beal_logger.sv
// beal_logger: commander and responder failing-address capture, responder
// node and command capture, and the multiple-error flag.
// assumes error flags are registered levels on clk_sys held until software
// clears them; strobes are one-cycle pulses on clk_sys.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (R1) commander capture locks on the commander bus-error flags or internal error
// (R2) issued command cycle loads commander length from data 31:30
// (R3) commander capture locks only after all retries failed (flag set)
// (R4) issued command cycle loads commander address from data 29:0
// (R5) commander capture resumes loading once the locking flag clears
// (R6) responder address loads on acknowledged I/O write, read or identify
// (R7) responder address, node and command lock on responder error flags
// (R8) responder length takes data 31:30 on accepted command cycle
// (R9) responder captures lock on failure, unlock when all such flags clear
// (R10) summary bits 25:20 capture requesting node, lock with responder
// (R11) summary bits 19:16 capture bus command, lock with responder
// (R12) summary bits 30:26 and 15 read zero
// (R13) multiple-error flag at bit 14 sets on second error, write one clears
// (R14) power-fail and self-test-fail flags never set multiple-error flag
// (R15) locked capture keeps every field of the first failing transaction
module beal_logger
  import beal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmdAddrIssue,
  input wire logic rspCmdAccept,
  input wire logic [31:0] busData,
  input wire logic [BEAL_NODE_W-1:0] rspNodeId,
  input wire logic [BEAL_CMD_W-1:0] rspCommand,
  input wire logic [31:0] busErrorFlags,
  input wire logic [BEAL_SUM_FLAG_W-1:0] summaryErrorFlags,
  input wire logic multiErrClear,
  output logic [31:0] commanderFailAddress,
  output logic [31:0] responderErrorAddress,
  output logic [31:0] errorSummary,
  output logic commanderLocked,
  output logic responderLocked
);

  logic [BEAL_NODE_W+BEAL_CMD_W-1:0] rspIdCmd;
  logic [BEAL_NODE_W+BEAL_CMD_W-1:0] rspIdCmdIn;
  logic [45:0] meFlags;
  logic [45:0] meFlagsPrev_q;
  logic meNewErr;
  logic meOldErr;
  logic multipleError_q;
  logic multipleError_d;
  // named fields so the checks read like the register layout
  logic [BEAL_LEN_MSB-BEAL_LEN_LSB:0] cmdrLength;
  logic [BEAL_ADDR_MSB-BEAL_ADDR_LSB:0] cmdrAddress;
  logic [BEAL_LEN_MSB-BEAL_LEN_LSB:0] rspLength;
  logic [BEAL_ADDR_MSB-BEAL_ADDR_LSB:0] rspAddress;
  logic [BEAL_NODE_W-1:0] rspNodeField;
  logic [BEAL_CMD_W-1:0] rspCmdField;
  logic multiErrBit;

  // one decode shared by both lock conditions
  function automatic logic beal_any_masked(
    input logic [31:0] busFlags,
    input logic [31:0] busMask,
    input logic [BEAL_SUM_FLAG_W-1:0] sumFlags,
    input logic [BEAL_SUM_FLAG_W-1:0] sumMask
  );
    return (|(busFlags & busMask)) || (|(sumFlags & sumMask));
  endfunction : beal_any_masked

  // flags are levels: they only set after the last retry, so lock follows
  assign commanderLocked = beal_any_masked(busErrorFlags, BEAL_CMDR_BE_MASK,
    summaryErrorFlags, BEAL_CMDR_ES_MASK); // (R1) (R3) (R5)
  assign responderLocked = beal_any_masked(busErrorFlags, BEAL_RSP_BE_MASK,
    summaryErrorFlags, BEAL_RSP_ES_MASK); // (R7) (R9)

  beal_capture #(.WIDTH(BEAL_CAP_W)) cmdrCap (
    .clk_sys(clk_sys),
    .rst(rst),
    .loadEn(cmdAddrIssue), // (R2) (R4)
    .lockHold(commanderLocked),
    .dataIn(busData),
    .dataQ(commanderFailAddress)
  );

  beal_capture #(.WIDTH(BEAL_CAP_W)) rspCap (
    .clk_sys(clk_sys),
    .rst(rst),
    .loadEn(rspCmdAccept), // (R6) (R8)
    .lockHold(responderLocked),
    .dataIn(busData),
    .dataQ(responderErrorAddress)
  );

  assign rspIdCmdIn = {rspNodeId, rspCommand};

  beal_capture #(.WIDTH(BEAL_NODE_W + BEAL_CMD_W)) idCmdCap (
    .clk_sys(clk_sys),
    .rst(rst),
    .loadEn(rspCmdAccept), // (R10) (R11)
    .lockHold(responderLocked),
    .dataIn(rspIdCmdIn),
    .dataQ(rspIdCmd)
  );

  // flags rising together belong to one transaction and are not a second error
  assign meFlags = {busErrorFlags & BEAL_ME_BE_MASK,
    summaryErrorFlags & BEAL_ME_ES_MASK}; // (R14)
  assign meNewErr = |(meFlags & ~meFlagsPrev_q);
  assign meOldErr = |(meFlags & meFlagsPrev_q);
  // set wins over a clear in the same cycle
  assign multipleError_d = (meNewErr && meOldErr)
    || (multipleError_q && !multiErrClear); // (R13)

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meFlagsPrev_q <= 46'h0;
      multipleError_q <= 1'b0;
    end else begin
      meFlagsPrev_q <= meFlags;
      multipleError_q <= multipleError_d;
    end
  end

  // low flag bits belong to other logic and are merged by the register read
  assign errorSummary = {6'h00,
    rspIdCmd[BEAL_NODE_W+BEAL_CMD_W-1:BEAL_CMD_W],
    rspIdCmd[BEAL_CMD_W-1:0], 1'b0, multipleError_q, 14'h0000}; // (R12)

  // field views of the visible registers
  assign cmdrLength = commanderFailAddress[BEAL_LEN_MSB:BEAL_LEN_LSB];
  assign cmdrAddress = commanderFailAddress[BEAL_ADDR_MSB:BEAL_ADDR_LSB];
  assign rspLength = responderErrorAddress[BEAL_LEN_MSB:BEAL_LEN_LSB];
  assign rspAddress = responderErrorAddress[BEAL_ADDR_MSB:BEAL_ADDR_LSB];
  assign rspNodeField = errorSummary[BEAL_SUM_NODE_MSB:BEAL_SUM_NODE_LSB];
  assign rspCmdField = errorSummary[BEAL_SUM_CMD_MSB:BEAL_SUM_CMD_LSB];
  assign multiErrBit = errorSummary[BEAL_SUM_ME_BIT];

  cmdr_load_a: assert property (@(posedge clk_sys) disable iff (rst) // (R2)
    cmdAddrIssue && !commanderLocked |=> commanderFailAddress == $past(busData))
    else $error("commander capture missed an issued cycle");

  cmdr_lock_a: assert property (@(posedge clk_sys) disable iff (rst) // (R1)
    commanderLocked |=> $stable(commanderFailAddress))
    else $error("commander capture changed while locked");

  cmdr_unlock_a: assert property (@(posedge clk_sys) disable iff (rst) // (R5)
    $fell(commanderLocked) && cmdAddrIssue ##1 1'b1
      |-> commanderFailAddress == $past(busData))
    else $error("commander capture did not resume after unlock");

  rsp_load_a: assert property (@(posedge clk_sys) disable iff (rst) // (R6)
    rspCmdAccept && !responderLocked |=> responderErrorAddress == $past(busData)
      && errorSummary[25:20] == $past(rspNodeId)
      && errorSummary[19:16] == $past(rspCommand))
    else $error("responder capture missed an accepted cycle");

  rsp_lock_a: assert property (@(posedge clk_sys) disable iff (rst) // (R7)
    responderLocked |=> $stable(responderErrorAddress) && $stable(errorSummary[25:16]))
    else $error("responder capture changed while locked");

  rsv_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // (R12)
    errorSummary[30:26] == 5'h00 && !errorSummary[15])
    else $error("reserved summary bits not zero");

  me_set_a: assert property (@(posedge clk_sys) disable iff (rst) // (R13)
    meNewErr && meOldErr |=> errorSummary[BEAL_SUM_ME_BIT])
    else $error("multiple-error flag not set");

  me_clear_a: assert property (@(posedge clk_sys) disable iff (rst) // (R13)
    multiErrClear && !(meNewErr && meOldErr) |=> !errorSummary[BEAL_SUM_ME_BIT])
    else $error("multiple-error flag not cleared");

  me_excl_a: assert property (@(posedge clk_sys) disable iff (rst) // (R14)
    !errorSummary[BEAL_SUM_ME_BIT] && (meFlags == meFlagsPrev_q)
      |=> !errorSummary[BEAL_SUM_ME_BIT])
    else $error("multiple-error flag set without a new error");

  cmdr_len_a: assert property (@(posedge clk_sys) disable iff (rst) // (R2)
    cmdAddrIssue && !commanderLocked |=> cmdrLength == $past(busData[31:30]))
    else $error("commander length not loaded");

  cmdr_addr_a: assert property (@(posedge clk_sys) disable iff (rst) // (R4)
    cmdAddrIssue && !commanderLocked |=> cmdrAddress == $past(busData[29:0]))
    else $error("commander address not loaded");

  cmdr_retry_a: assert property (@(posedge clk_sys) disable iff (rst) // (R3)
    cmdAddrIssue && !commanderLocked ##1 cmdAddrIssue && !commanderLocked
      |=> commanderFailAddress == $past(busData))
    else $error("open capture did not follow a retry");

  cmdr_keep_a: assert property (@(posedge clk_sys) disable iff (rst) // (R15)
    cmdAddrIssue && commanderLocked |=> $stable(commanderFailAddress))
    else $error("locked commander capture overwritten");

  cmdr_idle_a: assert property (@(posedge clk_sys) disable iff (rst) // (R4)
    !cmdAddrIssue |=> $stable(commanderFailAddress))
    else $error("commander capture changed with no issued cycle");

  rsp_len_a: assert property (@(posedge clk_sys) disable iff (rst) // (R8)
    rspCmdAccept && !responderLocked |=> rspLength == $past(busData[31:30]))
    else $error("responder length not loaded");

  rsp_addr_a: assert property (@(posedge clk_sys) disable iff (rst) // (R6)
    rspCmdAccept && !responderLocked |=> rspAddress == $past(busData[29:0]))
    else $error("responder address not loaded");

  rsp_node_a: assert property (@(posedge clk_sys) disable iff (rst) // (R10)
    rspCmdAccept && !responderLocked |=> rspNodeField == $past(rspNodeId))
    else $error("responder node not loaded");

  rsp_cmd_a: assert property (@(posedge clk_sys) disable iff (rst) // (R11)
    rspCmdAccept && !responderLocked |=> rspCmdField == $past(rspCommand))
    else $error("responder command not loaded");

  rsp_keep_a: assert property (@(posedge clk_sys) disable iff (rst) // (R15)
    rspCmdAccept && responderLocked
      |=> $stable(responderErrorAddress) && $stable(errorSummary[25:16]))
    else $error("locked responder capture overwritten");

  rsp_idle_a: assert property (@(posedge clk_sys) disable iff (rst) // (R6)
    !rspCmdAccept |=> $stable(responderErrorAddress) && $stable(errorSummary[25:16]))
    else $error("responder capture changed with no accepted cycle");

  rsp_unlock_a: assert property (@(posedge clk_sys) disable iff (rst) // (R9)
    $fell(responderLocked) && rspCmdAccept |=> responderErrorAddress == $past(busData))
    else $error("responder capture did not resume after unlock");

  me_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // (R13)
    multiErrBit && !multiErrClear |=> multiErrBit)
    else $error("multiple-error flag dropped without a clear");

  me_single_a: assert property (@(posedge clk_sys) disable iff (rst) // (R13)
    meNewErr && !meOldErr && !multiErrBit |=> !multiErrBit)
    else $error("multiple-error flag set by a first error");

  me_both_a: assert property (@(posedge clk_sys) disable iff (rst) // (R13)
    meNewErr && meOldErr && multiErrClear |=> multiErrBit)
    else $error("clear won over a new multiple error");

  me_stf_a: assert property (@(posedge clk_sys) disable iff (rst) // (R14)
    !multiErrBit && meFlags == meFlagsPrev_q && $changed(busErrorFlags[BEAL_BE_STF])
      |=> !multiErrBit)
    else $error("self-test flag set the multiple-error flag");

  me_aclo_a: assert property (@(posedge clk_sys) disable iff (rst) // (R14)
    !multiErrBit && meFlags == meFlagsPrev_q && $changed(summaryErrorFlags[BEAL_ES_ACLO])
      |=> !multiErrBit)
    else $error("power-fail flag set the multiple-error flag");

  sum_low_a: assert property (@(posedge clk_sys) disable iff (rst) // (R12)
    errorSummary[31] == 1'b0 && errorSummary[13:0] == 14'h0000)
    else $error("summary bits outside this logic not zero");

  rst_zero_a: assert property (@(posedge clk_sys) rst // (R12)
    |=> commanderFailAddress == 32'h0000_0000 && responderErrorAddress == 32'h0000_0000
      && errorSummary == 32'h0000_0000)
    else $error("register not zero after reset");

  // one check per flag, so a dropped or stray mask bit shows at once
  for (genvar g = 0; g < 32; g++) begin : g_busLock
    if (BEAL_CMDR_BE_MASK[g]) begin : g_cmdr
      cmdr_bit_a: assert property (@(posedge clk_sys) disable iff (rst) // (R1)
        busErrorFlags[g] |-> commanderLocked)
        else $error("commander flag left the capture open");
    end else begin : g_cmdrFree
      cmdr_free_a: assert property (@(posedge clk_sys) disable iff (rst) // (R1)
        busErrorFlags == (32'h1 << g) && summaryErrorFlags == 14'h0000 |-> !commanderLocked)
        else $error("unlisted flag locked the commander capture");
    end
    if (BEAL_RSP_BE_MASK[g]) begin : g_rsp
      rsp_bit_a: assert property (@(posedge clk_sys) disable iff (rst) // (R7)
        busErrorFlags[g] |-> responderLocked)
        else $error("responder flag left the capture open");
    end else begin : g_rspFree
      rsp_free_a: assert property (@(posedge clk_sys) disable iff (rst) // (R7)
        busErrorFlags == (32'h1 << g) && summaryErrorFlags == 14'h0000 |-> !responderLocked)
        else $error("unlisted flag locked the responder capture");
    end
  end

  // same per-flag checks for the summary flag group
  for (genvar g = 0; g < BEAL_SUM_FLAG_W; g++) begin : g_sumLock
    if (BEAL_CMDR_ES_MASK[g]) begin : g_cmdr
      cmdr_sum_a: assert property (@(posedge clk_sys) disable iff (rst) // (R1)
        summaryErrorFlags[g] |-> commanderLocked)
        else $error("summary flag left the commander capture open");
    end else begin : g_cmdrFree
      cmdr_sfree_a: assert property (@(posedge clk_sys) disable iff (rst) // (R1)
        summaryErrorFlags == (14'h1 << g) && busErrorFlags == 32'h0000_0000 |-> !commanderLocked)
        else $error("unlisted summary flag locked the commander capture");
    end
    if (BEAL_RSP_ES_MASK[g]) begin : g_rsp
      rsp_sum_a: assert property (@(posedge clk_sys) disable iff (rst) // (R7)
        summaryErrorFlags[g] |-> responderLocked)
        else $error("summary flag left the responder capture open");
    end else begin : g_rspFree
      rsp_sfree_a: assert property (@(posedge clk_sys) disable iff (rst) // (R7)
        summaryErrorFlags == (14'h1 << g) && busErrorFlags == 32'h0000_0000 |-> !responderLocked)
        else $error("unlisted summary flag locked the responder capture");
    end
  end

endmodule : beal_logger

`default_nettype wire

// >>> bench/beal_bus_node.sv
// beal_bus_node: far-side bus nodes that issue and accept command cycles.
// assumes requests come from the bench on clk_sys, one cycle ahead.
`timescale 1ns/10ps
`default_nettype none

module beal_bus_node (
  input wire logic clk_sys,
  input wire logic issueReq,
  input wire logic acceptReq,
  input wire logic [31:0] word,
  output var logic cmdAddrIssue,
  output var logic rspCmdAccept,
  output var logic [31:0] busData
);
  // idle lines flip each cycle so a stale word never passes for a capture
  always_ff @(posedge clk_sys) begin
    cmdAddrIssue <= issueReq;
    rspCmdAccept <= acceptReq;
    busData <= (issueReq | acceptReq) ? word : ~busData;
  end
endmodule : beal_bus_node

`default_nettype wire

// >>> bench/bus_error_address_logger_tb_top.sv
// bus_error_address_logger_tb_top: self-checking bench for beal_logger.
// assumes the logger's own assertions watch the run.
`timescale 1ns/10ps
`default_nettype none

module bus_error_address_logger_tb_top;
  import beal_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic issueReq = 1'b0;
  logic acceptReq = 1'b0;
  logic multiErrClear = 1'b0;
  logic [31:0] word = 32'h0;
  logic [31:0] busErrorFlags = 32'h0;
  logic [13:0] summaryErrorFlags = 14'h0;
  logic [5:0] rspNodeId = 6'h0;
  logic [3:0] rspCommand = 4'h0;
  wire logic cmdAddrIssue, rspCmdAccept, commanderLocked, responderLocked;
  wire logic [31:0] busData, commanderFailAddress, responderErrorAddress, errorSummary;
  int mismatches = 0;
  int comparisons = 0;
  int cb[6] = '{20, 18, 17, 16, 15, 13};
  int rb[7] = '{22, 21, 13, 12, 7, 6, 0};

  always #5 clk_sys = ~clk_sys;

  beal_bus_node u_node (.clk_sys(clk_sys), .issueReq(issueReq), .acceptReq(acceptReq),
    .word(word), .cmdAddrIssue(cmdAddrIssue), .rspCmdAccept(rspCmdAccept), .busData(busData));

  beal_logger u_dut (.clk_sys(clk_sys), .rst(rst), .cmdAddrIssue(cmdAddrIssue),
    .rspCmdAccept(rspCmdAccept), .busData(busData), .rspNodeId(rspNodeId),
    .rspCommand(rspCommand), .busErrorFlags(busErrorFlags),
    .summaryErrorFlags(summaryErrorFlags), .multiErrClear(multiErrClear),
    .commanderFailAddress(commanderFailAddress), .responderErrorAddress(responderErrorAddress),
    .errorSummary(errorSummary), .commanderLocked(commanderLocked),
    .responderLocked(responderLocked));

  function automatic logic [31:0] sumOf(input logic [31:0] w);
    return {6'h00, w[7:2], w[11:8], 16'h0000};
  endfunction : sumOf

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // node and command ride on the word so every transfer carries fresh ones
  task automatic xfer(input logic rsp, input logic [31:0] w);
    @(posedge clk_sys);
    issueReq <= !rsp;
    acceptReq <= rsp;
    word <= w;
    rspNodeId <= w[7:2];
    rspCommand <= w[11:8];
    @(posedge clk_sys);
    issueReq <= 1'b0;
    acceptReq <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : xfer

  task automatic flags(input logic [31:0] be, input logic [13:0] es);
    @(posedge clk_sys);
    busErrorFlags <= be;
    summaryErrorFlags <= es;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : flags

  task automatic t_cmdr(input logic [31:0] be, input logic [13:0] es);
    xfer(1'b0, 32'hC000_0001 ^ be);
    chk(commanderFailAddress, 32'hC000_0001 ^ be);
    flags(be, es);
    chk(commanderLocked, 32'h1);
    xfer(1'b0, 32'h3FFF_FFFE);
    chk(commanderFailAddress, 32'hC000_0001 ^ be);
    // issued cycle lands in the very cycle the flag clears
    @(posedge clk_sys);
    issueReq <= 1'b1;
    word <= 32'h8AAA_5555;
    @(posedge clk_sys);
    issueReq <= 1'b0;
    busErrorFlags <= 32'h0;
    summaryErrorFlags <= 14'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(commanderFailAddress, 32'h8AAA_5555);
  endtask : t_cmdr

  task automatic t_rsp(input logic [31:0] be, input logic [13:0] es);
    xfer(1'b1, 32'h4321_0FC4 ^ be);
    chk(responderErrorAddress, 32'h4321_0FC4 ^ be);
    chk(errorSummary, sumOf(32'h4321_0FC4 ^ be));
    flags(be, es | 14'h0040);
    chk(responderLocked, 32'h1);
    xfer(1'b1, 32'hBCDE_F03B);
    chk(responderErrorAddress, 32'h4321_0FC4 ^ be);
    chk(errorSummary, sumOf(32'h4321_0FC4 ^ be));
    flags(32'h0, 14'h0040);
    xfer(1'b1, 32'hBCDE_F03B);
    chk(responderErrorAddress, 32'h4321_0FC4 ^ be);
    flags(32'h0, 14'h0);
    xfer(1'b1, 32'hBCDE_F03B);
    chk(errorSummary, sumOf(32'hBCDE_F03B));
  endtask : t_rsp

  task automatic t_multi;
    flags(32'h1 << BEAL_BE_TMO, 14'h0);
    chk(errorSummary[14], 32'h0);
    flags((32'h1 << BEAL_BE_TMO) | (32'h1 << BEAL_BE_WSEQ), 14'h0);
    chk(errorSummary[14], 32'h1);
    @(posedge clk_sys);
    multiErrClear <= 1'b1;
    @(posedge clk_sys);
    multiErrClear <= 1'b0;
    #1;
    chk(errorSummary[14], 32'h0);
    flags(32'h0, 14'h0);
    flags(32'h1 << BEAL_BE_STF, 14'h0);
    flags((32'h1 << BEAL_BE_STF) | (32'h1 << BEAL_BE_TMO), 14'h0);
    flags(32'h0, 14'h0020);
    flags(32'h0, 14'h0021);
    chk(errorSummary[14], 32'h0);
  endtask : t_multi

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(commanderFailAddress | responderErrorAddress | errorSummary, 32'h0);
    foreach (cb[i]) t_cmdr(32'h1 << cb[i], 14'h0);
    t_cmdr(32'h0, 14'h0080);
    t_rsp(32'h1 << rb[0], 14'h0);
    t_rsp(32'h1 << rb[1], 14'h0);
    for (int i = 2; i < 7; i++) t_rsp(32'h0, 14'h1 << rb[i]);
    t_multi();
    close_out();
  end
endmodule : bus_error_address_logger_tb_top

`default_nettype wire
